// ### shared/sis_pkg.sv
// constants for the system integrity control/status block
package sis_pkg;
  // register map, byte address of the single register
  localparam logic [7:0] SIS_CTRL_STATUS_OFFSET = 8'h00;
  localparam logic [7:0] SIS_CTRL_STATUS_RESET = 8'h00;
  // field positions inside system_integrity_ctrl_status
  localparam int SIS_DETECT_SOURCE_SELECT_BIT = 7;
  localparam int SIS_VOLTAGE_IRQ_ENABLE_BIT = 6;
  localparam int SIS_VOLTAGE_LOW_FLAG_BIT = 5;
  localparam int SIS_LOWVOLT_RESET_FLAG_BIT = 4;
  localparam int SIS_WATCHDOG_RESET_FLAG_BIT = 0;
  // source select encodings
  localparam logic SIS_SRC_MAIN_SUPPLY = 1'h0;
  localparam logic SIS_SRC_EXT_PIN = 1'h1;
  // axi4-lite response codes
  localparam logic [1:0] SIS_RESP_OKAY = 2'h0;
  localparam logic [1:0] SIS_RESP_SLVERR = 2'h2;
  // synchroniser depth
  localparam int SIS_SYNC_STAGES = 2;
  // index of each pin in the synchronised input vector
  localparam int SIS_IN_DET_ENABLE = 0;
  localparam int SIS_IN_SUPPLY_LOW = 1;
  localparam int SIS_IN_EXT_LOW = 2;
  localparam int SIS_IN_COUNT = 3;
endpackage

// ### logic/sis_sync.sv
// two-stage synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module sis_sync
  import sis_pkg::*;
#(
  parameter int WIDTH = SIS_IN_COUNT
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // next values: first stage feeds only the second stage
  always_comb begin
    meta_d = i_async;
    sync_d = meta_q;
  end

  // one flop pair per bit
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          meta_q[g] <= 1'b0;
          sync_q[g] <= 1'b0;
        end else begin
          meta_q[g] <= meta_d[g];
          sync_q[g] <= sync_d[g];
        end
      end
    end
  endgenerate

  assign o_sync = sync_q;
endmodule // sis_sync

// ### logic/sis_top.sv
// system integrity control/status register with axi4-lite slave port
//
// Functional notes
// - bit 7 selects supply or external pin
// - detection works only when detector enabled
// - enabled flag change raises interrupt request
// - entering service routine clears pending request
// - voltage low flag is hardware read-only
// - low-voltage reset sets flag, zero write clears
// - flag undefined when detector disabled by option
// - watchdog reset sets, zero write clears flag
// - reset cause encoding from the two flags
//
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module sis_top
  import sis_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  // axi4-lite write address channel
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic [2:0] i_s_axi_awprot,
  // axi4-lite write data channel
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  // axi4-lite write response channel
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  output logic [1:0] o_s_axi_bresp,
  // axi4-lite read address channel
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  input wire logic [ADDR_W-1:0] i_s_axi_araddr,
  input wire logic [2:0] i_s_axi_arprot,
  // axi4-lite read data channel
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  // option configuration: low_voltage_detector enabled (pin level)
  input wire logic i_detector_enabled,
  // comparator outputs with hysteresis, high while below threshold
  input wire logic i_supply_below,
  input wire logic i_ext_pin_below,
  // reset cause levels from the reset controller, same clock
  input wire logic i_lowvolt_reset_cause,
  input wire logic i_watchdog_reset_cause,
  // cpu vectors into the voltage service routine (one-cycle pulse)
  input wire logic i_irq_ack,
  output logic o_voltage_irq,
  output logic o_voltage_low
);
  // synchronised pins
  logic [SIS_IN_COUNT-1:0] pins_raw;
  logic [SIS_IN_COUNT-1:0] pins_sync;
  logic det_enabled;
  logic supply_low;
  logic ext_low;

  // register fields
  logic src_sel_q;
  logic src_sel_d;
  logic irq_en_q;
  logic irq_en_d;
  logic vlow_q;
  logic vlow_d;
  logic lvd_rf_q;
  logic lvd_rf_d;
  logic wdg_rf_q;
  logic wdg_rf_d;
  logic irq_pend_q;
  logic irq_pend_d;
  logic out_of_reset_q;
  logic out_of_reset_d;
  logic capture_cause;
  logic [7:0] reg_value;

  // bus slave state
  logic aw_have_q;
  logic aw_have_d;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [ADDR_W-1:0] aw_addr_d;
  logic w_have_q;
  logic w_have_d;
  logic [31:0] w_data_q;
  logic [31:0] w_data_d;
  logic [3:0] w_strb_q;
  logic [3:0] w_strb_d;
  logic bvalid_q;
  logic bvalid_d;
  logic [1:0] bresp_q;
  logic [1:0] bresp_d;
  logic rvalid_q;
  logic rvalid_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0] rresp_q;
  logic [1:0] rresp_d;
  logic wr_fire;
  logic wr_hit;
  logic wr_lane0;
  logic rd_fire;
  logic rd_hit;

  // pins come from outside the clock domain
  assign pins_raw[SIS_IN_DET_ENABLE] = i_detector_enabled;
  assign pins_raw[SIS_IN_SUPPLY_LOW] = i_supply_below;
  assign pins_raw[SIS_IN_EXT_LOW] = i_ext_pin_below;

  sis_sync #(
    .WIDTH(SIS_IN_COUNT)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async(pins_raw),
    .o_sync(pins_sync)
  );

  assign det_enabled = pins_sync[SIS_IN_DET_ENABLE];
  assign supply_low = pins_sync[SIS_IN_SUPPLY_LOW];
  assign ext_low = pins_sync[SIS_IN_EXT_LOW];

  // handshakes: one write and one read in flight, ready drops while answering
  assign o_s_axi_awready = !aw_have_q && !bvalid_q;
  assign o_s_axi_wready = !w_have_q && !bvalid_q;
  assign o_s_axi_arready = !rvalid_q;
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign wr_hit = aw_addr_q[ADDR_W-1:2] == SIS_CTRL_STATUS_OFFSET[ADDR_W-1:2];
  assign wr_lane0 = wr_fire && wr_hit && w_strb_q[0];
  assign rd_fire = i_s_axi_arvalid && !rvalid_q;
  assign rd_hit = i_s_axi_araddr[ADDR_W-1:2] == SIS_CTRL_STATUS_OFFSET[ADDR_W-1:2];

  // write path: hold address and data until both are in, answer next cycle
  always_comb begin
    aw_have_d = aw_have_q;
    aw_addr_d = aw_addr_q;
    w_have_d = w_have_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (i_s_axi_awvalid && o_s_axi_awready) begin
      aw_have_d = 1'b1;
      aw_addr_d = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && o_s_axi_wready) begin
      w_have_d = 1'b1;
      w_data_d = i_s_axi_wdata;
      w_strb_d = i_s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = wr_hit ? SIS_RESP_OKAY : SIS_RESP_SLVERR;
    end
    if (bvalid_q && i_s_axi_bready) begin
      bvalid_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_have_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= SIS_RESP_OKAY;
    end else begin
      aw_have_q <= aw_have_d;
      aw_addr_q <= aw_addr_d;
      w_have_q <= w_have_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
    end
  end

  // live register image; reserved bits 3:1 always read zero
  always_comb begin
    reg_value = SIS_CTRL_STATUS_RESET;
    reg_value[SIS_DETECT_SOURCE_SELECT_BIT] = src_sel_q;
    reg_value[SIS_VOLTAGE_IRQ_ENABLE_BIT] = irq_en_q;
    reg_value[SIS_VOLTAGE_LOW_FLAG_BIT] = vlow_q;
    reg_value[SIS_LOWVOLT_RESET_FLAG_BIT] = lvd_rf_q;
    reg_value[SIS_WATCHDOG_RESET_FLAG_BIT] = wdg_rf_q;
  end

  // read path: data registered, unmapped words answer slverr with zero
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rd_fire) begin
      rvalid_d = 1'b1;
      rdata_d = rd_hit ? {24'h00_0000, reg_value} : 32'h0000_0000;
      rresp_d = rd_hit ? SIS_RESP_OKAY : SIS_RESP_SLVERR;
    end else if (rvalid_q && i_s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= SIS_RESP_OKAY;
    end else begin
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // reset cause is caught on the first clock after release, never under reset
  assign capture_cause = !out_of_reset_q;

  // control and flag next values
  always_comb begin
    out_of_reset_d = 1'b1;
    src_sel_d = src_sel_q;
    irq_en_d = irq_en_q;
    lvd_rf_d = lvd_rf_q;
    wdg_rf_d = wdg_rf_q;
    irq_pend_d = irq_pend_q;
    // software side; reserved bits are simply not stored
    if (wr_lane0) begin
      src_sel_d = w_data_q[SIS_DETECT_SOURCE_SELECT_BIT];
      irq_en_d = w_data_q[SIS_VOLTAGE_IRQ_ENABLE_BIT];
      // zero clears, one leaves the flag alone
      if (!w_data_q[SIS_LOWVOLT_RESET_FLAG_BIT]) begin
        lvd_rf_d = 1'b0;
      end
      if (!w_data_q[SIS_WATCHDOG_RESET_FLAG_BIT]) begin
        wdg_rf_d = 1'b0;
      end
    end
    // hardware sets after software clears so a coincident event wins
    if (capture_cause) begin
      if (i_lowvolt_reset_cause) begin
        lvd_rf_d = 1'b1;
        wdg_rf_d = 1'b0;
      end else if (i_watchdog_reset_cause) begin
        wdg_rf_d = 1'b1;
      end
    end
    // optioned out the flag holds, except at the release capture (enable sync reads 0)
    if (!det_enabled && !capture_cause) begin
      lvd_rf_d = lvd_rf_q;
    end
    // pending request: ack clears, a flag change in the same cycle wins
    if (i_irq_ack) begin
      irq_pend_d = 1'b0;
    end
    if (det_enabled && irq_en_q && (vlow_d != vlow_q)) begin
      irq_pend_d = 1'b1;
    end
    if (!irq_en_q || !det_enabled) begin
      irq_pend_d = 1'b0;
    end
  end

  // voltage low follows the selected comparator; forced low when optioned out
  always_comb begin
    if (!det_enabled) begin
      vlow_d = 1'b0;
    end else if (src_sel_q == SIS_SRC_EXT_PIN) begin
      vlow_d = ext_low;
    end else begin
      vlow_d = supply_low;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      out_of_reset_q <= 1'b0;
      src_sel_q <= SIS_CTRL_STATUS_RESET[SIS_DETECT_SOURCE_SELECT_BIT];
      irq_en_q <= SIS_CTRL_STATUS_RESET[SIS_VOLTAGE_IRQ_ENABLE_BIT];
      vlow_q <= SIS_CTRL_STATUS_RESET[SIS_VOLTAGE_LOW_FLAG_BIT];
      lvd_rf_q <= SIS_CTRL_STATUS_RESET[SIS_LOWVOLT_RESET_FLAG_BIT];
      wdg_rf_q <= SIS_CTRL_STATUS_RESET[SIS_WATCHDOG_RESET_FLAG_BIT];
      irq_pend_q <= 1'b0;
    end else begin
      out_of_reset_q <= out_of_reset_d;
      src_sel_q <= src_sel_d;
      irq_en_q <= irq_en_d;
      vlow_q <= vlow_d;
      lvd_rf_q <= lvd_rf_d;
      wdg_rf_q <= wdg_rf_d;
      irq_pend_q <= irq_pend_d;
    end
  end

  // outputs
  assign o_s_axi_bvalid = bvalid_q;
  assign o_s_axi_bresp = bresp_q;
  assign o_s_axi_rvalid = rvalid_q;
  assign o_s_axi_rdata = rdata_q;
  assign o_s_axi_rresp = rresp_q;
  assign o_voltage_irq = irq_pend_q;
  assign o_voltage_low = vlow_q;
endmodule // sis_top

// ### tb/sis_top_props.sv
// concurrent checks on the system integrity register block ports
`timescale 1ns/1ps
module sis_top_props (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_s_axi_awvalid,
  input wire logic o_s_axi_awready,
  input wire logic i_s_axi_wvalid,
  input wire logic o_s_axi_wready,
  input wire logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic i_detector_enabled,
  input wire logic i_irq_ack,
  input wire logic o_voltage_irq,
  input wire logic o_voltage_low
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // both write halves taken on one edge
  sequence wr_taken;
    i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
  endsequence
  // a flag move at the clearing edge would keep the request, so demand none
  sequence ack_quiet;
    i_irq_ack ##1 $stable(o_voltage_low);
  endsequence
  wr_answer_a: assert property (wr_taken |-> ##2 o_s_axi_bvalid)
    else $error("write answer late");
  rd_answer_a: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read answer late");
  b_hold_a: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid)
    else $error("bvalid dropped");
  r_hold_a: assert property (o_s_axi_rvalid && !i_s_axi_rready |=>
    o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("read data moved");
  irq_cause_a: assert property ($rose(o_voltage_irq) |-> $changed(o_voltage_low))
    else $error("request without flag change");
  ack_clear_a: assert property (ack_quiet |-> !o_voltage_irq)
    else $error("request kept after vector");
  det_off_a: assert property (!i_detector_enabled [*4] |->
    !o_voltage_low && !o_voltage_irq) else $error("detector off but active");
  flag_read_a: assert property ($rose(o_s_axi_rvalid) && $stable(o_voltage_low) |->
    o_s_axi_rdata[5] == o_voltage_low) else $error("flag read differs");
endmodule // sis_top_props
bind sis_top sis_top_props u_props (.*);

// ### tb/sis_cpu_model.sv
// cpu side model: takes the voltage vector after a set latency
`timescale 1ns/1ps
module sis_cpu_model (
  input wire logic i_clk,
  input wire logic i_irq,
  input wire logic [3:0] i_lat,
  output logic o_ack
);
  logic [3:0] wait_q = 4'h0;
  logic ack_q = 1'h0;
  assign o_ack = ack_q;
  // one-cycle vector pulse; count restarts so one request is not taken twice
  always @(posedge i_clk) begin
    if (!i_irq || ack_q) begin
      ack_q <= 1'h0;
      wait_q <= 4'h0;
    end else if (wait_q == i_lat) begin
      ack_q <= 1'h1;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule // sis_cpu_model

// ### tb/sis_top_tb.sv
// self-checking bench for the system integrity register block
`timescale 1ns/1ps
module sis_top_tb;
  import sis_pkg::*;
  logic i_clk = 1'h0, i_rst_n = 1'h0, i_irq_ack, irq_q = 1'h0;
  logic i_s_axi_awvalid = 1'h0, i_s_axi_wvalid = 1'h0, i_s_axi_bready = 1'h0;
  logic i_s_axi_arvalid = 1'h0, i_s_axi_rready = 1'h0, i_detector_enabled = 1'h1;
  logic i_supply_below = 1'h0, i_ext_pin_below = 1'h0;
  logic i_lowvolt_reset_cause = 1'h0, i_watchdog_reset_cause = 1'h0;
  logic [7:0] i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00;
  logic [2:0] i_s_axi_awprot = 3'h0, i_s_axi_arprot = 3'h0;
  logic [3:0] i_s_axi_wstrb = 4'hF, lat = 4'h0;
  logic [31:0] i_s_axi_wdata = 32'h0, o_s_axi_rdata, rdat;
  logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready;
  logic o_s_axi_rvalid, o_voltage_irq, o_voltage_low;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp, resp;
  int errors = 0, tests_run = 0, rises = 0, base;
  sis_top uut (.*);
  sis_cpu_model cpu (.i_clk, .i_irq(o_voltage_irq), .i_lat(lat), .o_ack(i_irq_ack));
  always #4 i_clk = ~i_clk;
  // count request rises, since a prompt vector can hide one from a late look
  always @(posedge i_clk) begin
    irq_q <= o_voltage_irq;
    if (o_voltage_irq && !irq_q) rises <= rises + 1;
  end
  task automatic summarize;
    if (errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s exp %0h got %0h", nm, exp, got);
    end
  endtask
  // ready is raised late on purpose so the slave must hold its answer
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    i_s_axi_awvalid <= 1'h1;
    i_s_axi_awaddr <= a;
    i_s_axi_wvalid <= 1'h1;
    i_s_axi_wdata <= {24'h0, d};
    for (n = 0; n < 40; n++) begin
      @(posedge i_clk);
      if (o_s_axi_awready) i_s_axi_awvalid <= 1'h0;
      if (o_s_axi_wready) i_s_axi_wvalid <= 1'h0;
      if (o_s_axi_bvalid && i_s_axi_bready) break;
      if (o_s_axi_bvalid) i_s_axi_bready <= 1'h1;
    end
    r = o_s_axi_bresp;
    i_s_axi_bready <= 1'h0;
    if (n == 40) begin
      errors++;
      summarize();
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    i_s_axi_arvalid <= 1'h1;
    i_s_axi_araddr <= a;
    for (n = 0; n < 40; n++) begin
      @(posedge i_clk);
      if (o_s_axi_arready) i_s_axi_arvalid <= 1'h0;
      if (o_s_axi_rvalid && i_s_axi_rready) break;
      if (o_s_axi_rvalid) i_s_axi_rready <= 1'h1;
    end
    d = o_s_axi_rdata;
    r = o_s_axi_rresp;
    i_s_axi_rready <= 1'h0;
    if (n == 40) begin
      errors++;
      summarize();
    end
  endtask
  task automatic rchk(input logic [7:0] exp);
    rd(SIS_CTRL_STATUS_OFFSET, rdat, resp);
    chk("register", rdat, {24'h0, exp});
    chk("read resp", {30'h0, resp}, {30'h0, SIS_RESP_OKAY});
  endtask
  task automatic do_rst(input logic lv, input logic wd);
    i_rst_n <= 1'h0;
    i_lowvolt_reset_cause <= lv;
    i_watchdog_reset_cause <= wd;
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'h1;
    repeat (2) @(posedge i_clk);
  endtask
  // move the comparators, then compare rise count and register
  task automatic step(input logic s, input logic e, input int dr, input logic [7:0] exp);
    base = rises;
    i_supply_below <= s;
    i_ext_pin_below <= e;
    repeat (12) @(posedge i_clk);
    chk("irq rises", rises - base, dr);
    chk("irq after vector", {31'h0, o_voltage_irq}, 32'h0);
    chk("flag pin", {31'h0, o_voltage_low}, {31'h0, exp[SIS_VOLTAGE_LOW_FLAG_BIT]});
    rchk(exp);
  endtask
  // each reset source leaves its mark; ones keep it, a zero write wipes it
  task automatic sc_causes;
    logic [7:0] exp [3] = '{8'h10, 8'h01, 8'h00};
    for (int k = 0; k < 3; k++) begin
      do_rst(k == 0, k < 2);
      rchk(exp[k]);
      wr(SIS_CTRL_STATUS_OFFSET, 8'hF1, resp);
      rchk(exp[k] | 8'hC0);
      wr(SIS_CTRL_STATUS_OFFSET, 8'h00, resp);
      rchk(8'h00);
    end
  endtask
  // both flag directions request service, on either monitored source
  task automatic sc_irq;
    wr(SIS_CTRL_STATUS_OFFSET, 8'h40, resp);
    step(1'h1, 1'h0, 1, 8'h60);
    lat <= 4'h4;
    step(1'h0, 1'h0, 1, 8'h40);
    wr(SIS_CTRL_STATUS_OFFSET, 8'hC0, resp);
    step(1'h0, 1'h1, 1, 8'hE0);
    step(1'h1, 1'h0, 1, 8'hC0);
    wr(SIS_CTRL_STATUS_OFFSET, 8'h80, resp);
    step(1'h0, 1'h1, 0, 8'hA0);
    step(1'h0, 1'h0, 0, 8'h80);
  endtask
  // detector off by option: flag and request stay quiet
  task automatic sc_det_off;
    wr(SIS_CTRL_STATUS_OFFSET, 8'hC0, resp);
    i_detector_enabled <= 1'h0;
    step(1'h0, 1'h1, 0, 8'hC0);
    step(1'h0, 1'h0, 0, 8'hC0);
    i_detector_enabled <= 1'h1;
  endtask
  // a word outside the map answers with an error and changes nothing
  task automatic sc_unmapped;
    rd(8'h04, rdat, resp);
    chk("bad read data", rdat, 32'h0000_0000);
    chk("bad read resp", {30'h0, resp}, {30'h0, SIS_RESP_SLVERR});
    wr(8'h04, 8'h40, resp);
    chk("bad write", {30'h0, resp}, {30'h0, SIS_RESP_SLVERR});
    rchk(8'hC0);
  endtask
  initial begin
    sc_causes;
    sc_irq;
    sc_det_off;
    sc_unmapped;
    summarize;
  end
endmodule // sis_top_tb
